// [shared/jlcr_pkg.sv]
// package: register offsets, field layout and reset values of the link bank
package jlcr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_LINKS = 2;
  // page control register (holds the link page select)
  localparam logic [11:0] ADDR_LINK_PAGE = 12'h300;
  localparam int PAGE_BIT = 0;
  // read-only per-lane ILAS capture registers
  localparam logic [11:0] ADDR_L6_LID = 12'h43A;
  localparam logic [11:0] ADDR_L6_RXSUM = 12'h43D;
  localparam logic [11:0] ADDR_L6_CSUM = 12'h43E;
  localparam logic [11:0] ADDR_L7_LID = 12'h442;
  localparam logic [11:0] ADDR_L7_RXSUM = 12'h445;
  localparam logic [11:0] ADDR_L7_CSUM = 12'h446;
  // writable expected-link parameters
  localparam logic [11:0] ADDR_DID = 12'h450;
  localparam logic [11:0] ADDR_BID = 12'h451;
  localparam logic [11:0] ADDR_LID0 = 12'h452;
  localparam logic [11:0] ADDR_SCR_L = 12'h453;
  localparam logic [11:0] ADDR_F = 12'h454;
  localparam logic [11:0] ADDR_K = 12'h455;
  // field positions
  localparam int LID_W = 5;
  localparam int LMFC_ADJUST_DIRECTION_BIT = 6;
  localparam int PHASE_ADJUST_REQUEST_BIT = 5;
  localparam int SCR_BIT = 7;
  localparam int L_W = 5;
  localparam int K_W = 5;
  // reset values
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [4:0] RST_ZERO5 = 5'h00;
  localparam logic RST_SCR = 1'b1;
  localparam logic [4:0] RST_L = 5'h07;
  localparam logic [4:0] RST_K = 5'h1F;
endpackage : jlcr_pkg

// [logic/jlcr_lane_capture.sv]
// one lane's captured ILAS values for both link pages
`timescale 1ns/10ps
`default_nettype none
module jlcr_lane_capture #(
  parameter int LINKS = 2
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  // capture strobe from the lane receiver
  input wire logic i_capture,
  input wire logic [$clog2(LINKS)-1:0] i_link,
  input wire logic [4:0] i_lane_number,
  input wire logic [7:0] i_rx_sum,
  input wire logic [7:0] i_calc_sum,
  // page select for reads
  input wire logic [$clog2(LINKS)-1:0] i_page,
  // page-selected stored values
  output logic [4:0] o_lane_number,
  output logic [7:0] o_rx_sum,
  output logic [7:0] o_calc_sum
);
  // one set of storage per link instance
  logic [4:0] lid_r [LINKS];
  logic [7:0] rxs_r [LINKS];
  logic [7:0] cms_r [LINKS];

  // capture on the receiver's strobe; storage cleared at reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < LINKS; k++) begin
        lid_r[k] <= jlcr_pkg::RST_ZERO5;
        rxs_r[k] <= jlcr_pkg::RST_ZERO8;
        cms_r[k] <= jlcr_pkg::RST_ZERO8;
      end
    end else if (i_enable && i_capture) begin
      lid_r[i_link] <= i_lane_number;
      rxs_r[i_link] <= i_rx_sum;
      cms_r[i_link] <= i_calc_sum;
    end
  end

  // read view follows the page
  assign o_lane_number = lid_r[i_page];
  assign o_rx_sum = rxs_r[i_page];
  assign o_calc_sum = cms_r[i_page];
endmodule : jlcr_lane_capture
`default_nettype wire

// [logic/jlcr_sum_calc.sv]
// checksum over the received link configuration fields
`timescale 1ns/10ps
`default_nettype none
module jlcr_sum_calc (
  // received configuration octets, already packed per octet
  input wire logic [8*14-1:0] i_config,
  // modulo-256 sum
  output logic [7:0] o_sum
);
  // sum of all octets, truncated to eight bits as the link defines
  always_comb begin
    o_sum = 8'h00;
    for (int k = 0; k < 14; k++) begin
      o_sum = o_sum + i_config[8*k +: 8];
    end
  end
endmodule : jlcr_sum_calc
`default_nettype wire

// [logic/jlcr_regs.sv]
// link configuration register bank, paged by link
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - every register except the page select and the link 0 adjust bits follows the link page select
// - capture received lane ID, reset zero
// - store received checksum octet, reset zero
// - compute own checksum, expose read-only
// - writable device number, reset zero
// - writable bank number, reset zero
// - bit six: LMFC adjust direction, link 0
// - bit five: phase adjust request, link 0
// - bits four-zero: lane number in link
// - descramble enable, resets to one
// - lane count minus one, reset seven
// - octets per frame minus one, reset zero
// - frames per multiframe minus one, reset 31
module jlcr_regs #(
  parameter int LINKS = jlcr_pkg::NUM_LINKS
) (
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // lane 6 ILAS capture
  input wire logic i_lane6_capture,
  input wire logic [4:0] i_lane6_received_lane_number,
  input wire logic [7:0] i_lane6_received_sum,
  input wire logic [8*14-1:0] i_lane6_config,
  // lane 7 ILAS capture
  input wire logic i_lane7_capture,
  input wire logic [4:0] i_lane7_received_lane_number,
  input wire logic [7:0] i_lane7_received_sum,
  input wire logic [8*14-1:0] i_lane7_config,
  // link whose ILAS is being received
  input wire logic [$clog2(LINKS)-1:0] i_capture_link,
  // link 0 parameters to the deserializer
  output logic [7:0] o_device_link_number,
  output logic [7:0] o_bank_number,
  output logic o_lmfc_adjust_direction,
  output logic o_phase_adjust_request,
  output logic [4:0] o_lane_number_in_link,
  output logic o_descramble_enable,
  output logic [4:0] o_lane_count_m1,
  output logic [7:0] o_octets_per_frame_m1,
  output logic [4:0] o_frames_per_multiframe_m1
);
  localparam int PW = $clog2(LINKS);

  // page select register
  logic [PW-1:0] page_r;
  // per-link parameter storage
  logic [7:0] did_r [LINKS];
  logic [7:0] bid_r [LINKS];
  logic [4:0] lid_r [LINKS];
  logic [4:0] l_r [LINKS];
  logic [7:0] f_r [LINKS];
  logic [4:0] k_r [LINKS];
  logic scr_r [LINKS];
  // direction and phase request exist for link 0 only
  logic lmfc_adjust_direction_r;
  logic phase_adjust_request_r;
  // read data register
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // lane capture views
  logic [4:0] l6_lid, l7_lid;
  logic [7:0] l6_rx, l7_rx, l6_cm, l7_cm;
  logic [7:0] l6_calc, l7_calc;
  logic wr_ok;

  assign wr_ok = i_enable && i_wr;

  // computed sums for each lane
  jlcr_sum_calc u_sum6 (
    .i_config(i_lane6_config),
    .o_sum(l6_calc)
  );
  jlcr_sum_calc u_sum7 (
    .i_config(i_lane7_config),
    .o_sum(l7_calc)
  );

  // lane 6 capture storage
  jlcr_lane_capture #(.LINKS(LINKS)) u_lane6 (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(i_enable),
    .i_capture(i_lane6_capture),
    .i_link(i_capture_link),
    .i_lane_number(i_lane6_received_lane_number),
    .i_rx_sum(i_lane6_received_sum),
    .i_calc_sum(l6_calc),
    .i_page(page_r),
    .o_lane_number(l6_lid),
    .o_rx_sum(l6_rx),
    .o_calc_sum(l6_cm)
  );

  // lane 7 capture storage
  jlcr_lane_capture #(.LINKS(LINKS)) u_lane7 (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(i_enable),
    .i_capture(i_lane7_capture),
    .i_link(i_capture_link),
    .i_lane_number(i_lane7_received_lane_number),
    .i_rx_sum(i_lane7_received_sum),
    .i_calc_sum(l7_calc),
    .i_page(page_r),
    .o_lane_number(l7_lid),
    .o_rx_sum(l7_rx),
    .o_calc_sum(l7_cm)
  );

  // page select write
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_r <= '0;
    end else if (wr_ok && i_addr == jlcr_pkg::ADDR_LINK_PAGE) begin
      page_r <= i_wdata[jlcr_pkg::PAGE_BIT +: PW];
    end
  end

  // paged parameter writes; reserved bits are simply not stored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < LINKS; k++) begin
        did_r[k] <= jlcr_pkg::RST_ZERO8;
        bid_r[k] <= jlcr_pkg::RST_ZERO8;
        lid_r[k] <= jlcr_pkg::RST_ZERO5;
        scr_r[k] <= jlcr_pkg::RST_SCR;
        l_r[k] <= jlcr_pkg::RST_L;
        f_r[k] <= jlcr_pkg::RST_ZERO8;
        k_r[k] <= jlcr_pkg::RST_K;
      end
    end else if (wr_ok) begin
      unique case (i_addr)
        jlcr_pkg::ADDR_DID: begin
          did_r[page_r] <= i_wdata;
        end
        jlcr_pkg::ADDR_BID: begin
          // held stable by software outside deserializer reset
          bid_r[page_r] <= i_wdata;
        end
        jlcr_pkg::ADDR_LID0: begin
          lid_r[page_r] <= i_wdata[jlcr_pkg::LID_W-1:0];
        end
        jlcr_pkg::ADDR_SCR_L: begin
          scr_r[page_r] <= i_wdata[jlcr_pkg::SCR_BIT];
          l_r[page_r] <= i_wdata[jlcr_pkg::L_W-1:0];
        end
        jlcr_pkg::ADDR_F: begin
          f_r[page_r] <= i_wdata;
        end
        jlcr_pkg::ADDR_K: begin
          k_r[page_r] <= i_wdata[jlcr_pkg::K_W-1:0];
        end
        default: begin
          // other addresses hold nothing here
        end
      endcase
    end
  end

  // link-0-only phase controls: writes on other pages are ignored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lmfc_adjust_direction_r <= 1'b0;
      phase_adjust_request_r <= 1'b0;
    end else if (wr_ok && i_addr == jlcr_pkg::ADDR_LID0 && page_r == '0) begin
      lmfc_adjust_direction_r <= i_wdata[jlcr_pkg::LMFC_ADJUST_DIRECTION_BIT];
      phase_adjust_request_r <= i_wdata[jlcr_pkg::PHASE_ADJUST_REQUEST_BIT];
    end
  end

  // read mux; unmapped addresses and reserved bits return zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (i_addr)
      jlcr_pkg::ADDR_LINK_PAGE: rdata_nxt[jlcr_pkg::PAGE_BIT +: PW] = page_r;
      jlcr_pkg::ADDR_L6_LID: rdata_nxt[4:0] = l6_lid;
      jlcr_pkg::ADDR_L6_RXSUM: rdata_nxt = l6_rx;
      jlcr_pkg::ADDR_L6_CSUM: rdata_nxt = l6_cm;
      jlcr_pkg::ADDR_L7_LID: rdata_nxt[4:0] = l7_lid;
      jlcr_pkg::ADDR_L7_RXSUM: rdata_nxt = l7_rx;
      jlcr_pkg::ADDR_L7_CSUM: rdata_nxt = l7_cm;
      jlcr_pkg::ADDR_DID: rdata_nxt = did_r[page_r];
      jlcr_pkg::ADDR_BID: rdata_nxt = bid_r[page_r];
      jlcr_pkg::ADDR_LID0: begin
        rdata_nxt[4:0] = lid_r[page_r];
        if (page_r == '0) begin
          rdata_nxt[jlcr_pkg::LMFC_ADJUST_DIRECTION_BIT] = lmfc_adjust_direction_r;
          rdata_nxt[jlcr_pkg::PHASE_ADJUST_REQUEST_BIT] = phase_adjust_request_r;
        end
      end
      jlcr_pkg::ADDR_SCR_L: begin
        rdata_nxt[jlcr_pkg::SCR_BIT] = scr_r[page_r];
        rdata_nxt[4:0] = l_r[page_r];
      end
      jlcr_pkg::ADDR_F: rdata_nxt = f_r[page_r];
      jlcr_pkg::ADDR_K: rdata_nxt[4:0] = k_r[page_r];
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else if (i_enable) begin
      rdata_r <= i_rd ? rdata_nxt : 8'h00;
    end
  end
  assign o_rdata = rdata_r;

  // link 0 parameters drive the deserializer; outputs are flops
  assign o_device_link_number = did_r[0];
  assign o_bank_number = bid_r[0];
  assign o_lmfc_adjust_direction = lmfc_adjust_direction_r;
  assign o_phase_adjust_request = phase_adjust_request_r;
  assign o_lane_number_in_link = lid_r[0];
  assign o_descramble_enable = scr_r[0];
  assign o_lane_count_m1 = l_r[0];
  assign o_octets_per_frame_m1 = f_r[0];
  assign o_frames_per_multiframe_m1 = k_r[0];
endmodule : jlcr_regs
`default_nettype wire

// [test/jlcr_regs_checker.sv]
// checker: register port timing and link 0 outputs of the bank
`timescale 1ns/10ps
`default_nettype none
module jlcr_regs_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire logic i_enable,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // link 0 outputs
  input wire logic [7:0] o_device_link_number,
  input wire logic o_lmfc_adjust_direction,
  input wire logic o_phase_adjust_request,
  input wire logic [4:0] o_lane_number_in_link,
  input wire logic o_descramble_enable,
  input wire logic [4:0] o_lane_count_m1,
  input wire logic [4:0] o_frames_per_multiframe_m1
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // page shadow: writes only reach the link 0 outputs while page is 0
  logic page_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) page_r <= 1'b0;
    else if (i_enable && i_wr && i_addr == jlcr_pkg::ADDR_LINK_PAGE)
      page_r <= i_wdata[0];
  end
  wire rd_e = i_enable && i_rd; // a read that is taken
  wire wr0 = i_enable && i_wr && !page_r; // a link 0 write that is taken
  property p_rd_idle;
    i_enable && !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_lid_res;
    rd_e && (i_addr == jlcr_pkg::ADDR_L6_LID || i_addr == jlcr_pkg::ADDR_L7_LID)
      |=> o_rdata[7:5] == 3'h0;
  endproperty
  a_lid_res: assert property (p_lid_res) else $error("lane id top bits set");
  property p_k_res;
    rd_e && i_addr == jlcr_pkg::ADDR_K |=> o_rdata[7:5] == 3'h0;
  endproperty
  a_k_res: assert property (p_k_res) else $error("frame count top bits set");
  property p_scr_wr;
    wr0 && i_addr == jlcr_pkg::ADDR_SCR_L |=> o_descramble_enable ==
      $past(i_wdata[7]) && o_lane_count_m1 == $past(i_wdata[4:0]);
  endproperty
  a_scr_wr: assert property (p_scr_wr) else $error("scramble/lanes wrong");
  property p_did_wr;
    wr0 && i_addr == jlcr_pkg::ADDR_DID |=> o_device_link_number == $past(i_wdata);
  endproperty
  a_did_wr: assert property (p_did_wr) else $error("device number wrong");
  property p_k_wr;
    wr0 && i_addr == jlcr_pkg::ADDR_K |=>
      o_frames_per_multiframe_m1 == $past(i_wdata[4:0]);
  endproperty
  a_k_wr: assert property (p_k_wr) else $error("frame count wrong");
  property p_lid0_wr;
    wr0 && i_addr == jlcr_pkg::ADDR_LID0 |=> {o_lmfc_adjust_direction,
      o_phase_adjust_request, o_lane_number_in_link} == $past(i_wdata[6:0]);
  endproperty
  a_lid0_wr: assert property (p_lid0_wr) else $error("lane0 id wrong");
  property p_page1;
    i_wr && page_r && i_addr == jlcr_pkg::ADDR_DID |=> $stable(o_device_link_number);
  endproperty
  a_page1: assert property (p_page1) else $error("page 1 write leaked");
  c_scr_wr: cover property (wr0 && i_addr == jlcr_pkg::ADDR_SCR_L);
  c_page1: cover property (i_wr && page_r);
  c_rd_k: cover property (rd_e && i_addr == jlcr_pkg::ADDR_K);
endmodule : jlcr_regs_checker
bind jlcr_regs jlcr_regs_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_enable(i_enable), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_device_link_number(o_device_link_number),
  .o_lmfc_adjust_direction(o_lmfc_adjust_direction),
  .o_phase_adjust_request(o_phase_adjust_request),
  .o_lane_number_in_link(o_lane_number_in_link),
  .o_descramble_enable(o_descramble_enable), .o_lane_count_m1(o_lane_count_m1),
  .o_frames_per_multiframe_m1(o_frames_per_multiframe_m1));
`default_nettype wire

// [test/jlcr_lane_source.sv]
// lane transmitter stand-in: hands one ILAS value set over on request
`timescale 1ns/10ps
`default_nettype none
module jlcr_lane_source (
  // clock and request
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [7:0] i_seed,
  // values toward the bank
  output logic o_capture,
  output logic [4:0] o_lane_number,
  output logic [7:0] o_rx_sum,
  output logic [8*14-1:0] o_config
);
  initial begin
    o_capture = 1'b0;
    o_lane_number = 5'h00;
    o_rx_sum = 8'h00;
    o_config = '0;
  end
  // values hold only in the pulse cycle; otherwise they toggle so a late
  // sample by the bank cannot match by luck
  always @(posedge i_clock) begin
    o_capture <= i_go;
    o_lane_number <= i_go ? i_seed[4:0] : ~o_lane_number;
    o_rx_sum <= i_go ? ~i_seed : ~o_rx_sum;
    for (int i = 0; i < 14; i++)
      o_config[8*i +: 8] <= i_go ? i_seed + 8'(i) : ~o_config[8*i +: 8];
  end
endmodule : jlcr_lane_source
`default_nettype wire

// [test/jlcr_regs_tb.sv]
// testbench for the link configuration register bank
`timescale 1ns/10ps
`default_nettype none
module jlcr_regs_tb;
  // design and partner signals
  logic i_clock, i_rst_n, i_enable, i_wr, i_rd, i_capture_link;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, device_link_number, bank_number, f, seed6, seed7, rx6, rx7;
  logic [4:0] lane, lcount, kcount, lid6, lid7;
  logic adj, phase, desc, go6, go7, cap6, cap7;
  logic [8*14-1:0] cfg6, cfg7;
  int num_errors = 0;
  int check_count = 0;
  // writable registers, reset values and read-back after writing all ones
  logic [11:0] ra [6] = '{jlcr_pkg::ADDR_DID, jlcr_pkg::ADDR_BID,
    jlcr_pkg::ADDR_LID0, jlcr_pkg::ADDR_SCR_L, jlcr_pkg::ADDR_F, jlcr_pkg::ADDR_K};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h1F};
  logic [7:0] wv [6] = '{8'hFF, 8'hFF, 8'h7F, 8'h9F, 8'hFF, 8'h1F};
  jlcr_regs dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(i_enable),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_lane6_capture(cap6),
    .i_lane6_received_lane_number(lid6), .i_lane6_received_sum(rx6),
    .i_lane6_config(cfg6), .i_lane7_capture(cap7),
    .i_lane7_received_lane_number(lid7), .i_lane7_received_sum(rx7),
    .i_lane7_config(cfg7), .i_capture_link(i_capture_link),
    .o_device_link_number(device_link_number), .o_bank_number(bank_number),
    .o_lmfc_adjust_direction(adj), .o_phase_adjust_request(phase),
    .o_lane_number_in_link(lane), .o_descramble_enable(desc),
    .o_lane_count_m1(lcount), .o_octets_per_frame_m1(f),
    .o_frames_per_multiframe_m1(kcount));
  jlcr_lane_source src6 (.i_clock(i_clock), .i_go(go6), .i_seed(seed6),
    .o_capture(cap6), .o_lane_number(lid6), .o_rx_sum(rx6), .o_config(cfg6));
  jlcr_lane_source src7 (.i_clock(i_clock), .i_go(go7), .i_seed(seed7),
    .o_capture(cap7), .o_lane_number(lid7), .o_rx_sum(rx7), .o_config(cfg7));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe; data only stands in the following cycle
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd
  // modulo-256 sum of the fourteen octets the stand-in sends
  function automatic logic [7:0] csum(input logic [7:0] s);
    csum = 8'h00;
    for (int i = 0; i < 14; i++) csum += s + 8'(i);
  endfunction : csum
  // ask one lane stand-in for a capture on the given link
  task automatic cap(input logic l7, input logic link, input logic [7:0] s);
    @(posedge i_clock);
    i_capture_link <= link;
    if (l7) begin
      go7 <= 1'b1;
      seed7 <= s;
    end else begin
      go6 <= 1'b1;
      seed6 <= s;
    end
    @(posedge i_clock);
    go6 <= 1'b0;
    go7 <= 1'b0;
    @(posedge i_clock);
  endtask : cap
  // lane id, received sum and computed sum of one lane, or all zero
  task automatic lane_chk(input logic [11:0] b, input bit on, input logic [7:0] s);
    rd(b, on ? {3'h0, s[4:0]} : 8'h00);
    rd(b + 12'h3, on ? ~s : 8'h00);
    rd(b + 12'h4, on ? csum(s) : 8'h00);
  endtask : lane_chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // hang guard, far beyond the roughly 120 cycles the tests need
  initial begin
    #500us;
    num_errors++;
    print_verdict();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, go6, go7, i_capture_link} = '0;
    i_enable = 1'b1;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    {seed6, seed7} = '0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    // reset values, then all-ones writes with reserved bits dropped
    foreach (ra[i]) rd(ra[i], rv[i]);
    lane_chk(jlcr_pkg::ADDR_L6_LID, 0, 8'h00);
    lane_chk(jlcr_pkg::ADDR_L7_LID, 0, 8'h00);
    foreach (ra[i]) wr(ra[i], 8'hFF);
    wr(jlcr_pkg::ADDR_L6_RXSUM, 8'hFF);
    wr(12'h457, 8'hFF);
    foreach (ra[i]) rd(ra[i], wv[i]);
    rd(jlcr_pkg::ADDR_L6_RXSUM, 8'h00);
    chk(device_link_number, 8'hFF);
    chk(bank_number, 8'hFF);
    chk({1'b0, adj, phase, lane}, 8'h7F);
    chk({desc, 2'b00, lcount}, 8'h9F);
    chk(f, 8'hFF);
    chk({3'h0, kcount}, 8'h1F);
    wr(jlcr_pkg::ADDR_SCR_L, 8'h03);
    // let the write edge settle before looking at the level outputs
    #1 chk({desc, 2'b00, lcount}, 8'h03);
    // a write with the clock enable low is lost
    @(posedge i_clock) i_enable <= 1'b0;
    wr(jlcr_pkg::ADDR_DID, 8'h11);
    i_enable <= 1'b1;
    rd(jlcr_pkg::ADDR_DID, 8'hFF);
    // page 1 has its own set; adjust bits are link 0 only
    wr(jlcr_pkg::ADDR_LINK_PAGE, 8'h01);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(jlcr_pkg::ADDR_DID, 8'h5A);
    wr(jlcr_pkg::ADDR_LID0, 8'h7F);
    rd(jlcr_pkg::ADDR_DID, 8'h5A);
    rd(jlcr_pkg::ADDR_LID0, 8'h1F);
    chk(device_link_number, 8'hFF);
    // captures land only in their own link page
    cap(0, 0, 8'h23);
    cap(1, 1, 8'h41);
    lane_chk(jlcr_pkg::ADDR_L6_LID, 0, 8'h00);
    lane_chk(jlcr_pkg::ADDR_L7_LID, 1, 8'h41);
    wr(jlcr_pkg::ADDR_LINK_PAGE, 8'h00);
    lane_chk(jlcr_pkg::ADDR_L6_LID, 1, 8'h23);
    lane_chk(jlcr_pkg::ADDR_L7_LID, 0, 8'h00);
    rd(jlcr_pkg::ADDR_DID, 8'hFF);
    print_verdict();
  end
endmodule : jlcr_regs_tb
`default_nettype wire
